// [design/mpcd_top.sv]
// mpcd_top: multifunction pin code decoder with apb register access.
// assumes: pin inputs synchronous to pclk, status bits from the device core,
// effective control bits consumed by the loops and output drivers.
//
// Overview of operation
// RQ1 - code 3E: primary phase step and mask
// RQ2 - codes 3F/40: primary fast acquisition flags
// RQ3 - control 40/60: chain power-down bits
// RQ4 - control 41/42: primary freerun, holdover requests
// RQ5 - control 43: clear primary tuning history
// RQ6 - control 44: first distribution sync request
// RQ7 - control 45..47: profile select bits 0..2
// RQ8 - status 41: primary feedback divider resync
// RQ9 - status 42: OR of slew limiters
// RQ10 - status 43: OR of phase offset errors
// RQ11 - control 50..58: per-output mute and reset
// RQ12 - control 59/5A: mute all, reset all
// RQ13 - control 5B: counted pulse burst request
// RQ14 - status 50..53: secondary lock and calibration flags
// RQ15 - status 54: secondary loop active indication
// RQ16 - status 55..57: secondary freerun, holdover, switching
// RQ17 - status 58/5A/5B: secondary history, clamp, slew
// RQ18 - status 59: history update event and mask
// RQ19 - status 5C: second distribution sync and mask
// RQ20 - status 5E: secondary phase step and mask
// RQ21 - status 5F/60: secondary fast acquisition flags
// RQ22 - unassigned codes: no effect, pin low
// RQ23 - host holds control level several cycles
`timescale 1ns/1ps
module mpcd_top #(
    parameter int NUM_PINS = 4                          // multifunction pins
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire mpcd_pkg::mpcd_sts_t   sts,
    input  wire logic [NUM_PINS-1:0]   pin_in,
    output logic [NUM_PINS-1:0]        pin_out,
    output logic [NUM_PINS-1:0]        pin_oe,
    output logic [mpcd_pkg::CTL_W-1:0] ctl_eff
);

    // address classes
    typedef enum logic [4:0] {
        MPCD_A_PCFG = 5'b00001,
        MPCD_A_SW   = 5'b00010,
        MPCD_A_EFF  = 5'b00100,
        MPCD_A_PIN  = 5'b01000,
        MPCD_A_BAD  = 5'b10000
    } mpcd_acls_t;

    mpcd_pkg::mpcd_pcfg_t          pcfg_reg [NUM_PINS];  // per-pin config
    logic [mpcd_pkg::CTL_W-1:0]    ctl_sw_reg;           // software control bits
    logic [mpcd_pkg::CTL_W-1:0]    ctl_eff_next;         // bits after pin proxies
    logic [4:0]                    prox_idx [NUM_PINS];  // proxied bit per pin
    logic [31:0]                   rdata_next;           // read mux
    logic                          wr_en;                // write takes effect
    logic                          setup_rd;             // read setup phase
    mpcd_acls_t                    acls;                 // class of paddr
    logic [2:0]                    pin_sel;              // config word index

    // classify an address; used by write and read paths
    function automatic mpcd_acls_t addr_cls(input logic [11:0] a);
        mpcd_acls_t r;
        r = MPCD_A_BAD;
        if (a[1:0] != 2'b00) begin
            r = MPCD_A_BAD;
        end else if (a < mpcd_pkg::REG_PCFG_BASE + 12'(4 * NUM_PINS)) begin
            r = MPCD_A_PCFG;
        end else if (a == mpcd_pkg::REG_CTL_SW) begin
            r = MPCD_A_SW;
        end else if (a == mpcd_pkg::REG_CTL_EFF) begin
            r = MPCD_A_EFF;
        end else if (a == mpcd_pkg::REG_PIN_ST) begin
            r = MPCD_A_PIN;
        end
        return r;
    endfunction

    // bus decode, zero wait states
    assign acls     = addr_cls(paddr);
    assign pin_sel  = paddr[4:2];
    assign wr_en    = psel & penable & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;

    // pin cells: status drive and control proxy index
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        mpcd_pin_cell u_cell (
            .pclk     (pclk),
            .presetn  (presetn),
            .cfg      (pcfg_reg[p]),
            .sts      (sts),
            .pin_out  (pin_out[p]),
            .pin_oe   (pin_oe[p]),
            .prox_idx (prox_idx[p])
        );

        // config word write
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pcfg_reg[p] <= mpcd_pkg::PCFG_RST;
            end else if (wr_en && acls == MPCD_A_PCFG && pin_sel == 3'(p)) begin
                pcfg_reg[p].code   <= pwdata[mpcd_pkg::PCFG_CODE_LSB +: 7];
                pcfg_reg[p].dir_in <= pwdata[mpcd_pkg::PCFG_DIR_BIT];
            end
        end
    end

    // software control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_sw_reg <= mpcd_pkg::CTL_SW_RST;
        end else if (wr_en && acls == MPCD_A_SW) begin
            ctl_sw_reg <= pwdata[mpcd_pkg::CTL_W-1:0];
        end
    end

    // pin levels override software bits; lowest pin index wins
    always_comb begin
        ctl_eff_next = ctl_sw_reg;
        for (int p = NUM_PINS - 1; p >= 0; p--) begin
            // unassigned codes leave every bit alone, see RQ22
            if (prox_idx[p] != mpcd_pkg::CTL_NONE) begin
                ctl_eff_next[prox_idx[p]] = pin_in[p];  // see RQ3 see RQ4 see RQ5
            end
        end
    end

    // effective control bits, one register stage from pin to bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_eff <= mpcd_pkg::CTL_SW_RST;
        end else begin
            ctl_eff <= ctl_eff_next;  // see RQ6 see RQ7 see RQ11 see RQ12 see RQ13
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (acls)
            MPCD_A_PCFG: begin
                for (int p = 0; p < NUM_PINS; p++) begin
                    if (pin_sel == 3'(p)) begin
                        rdata_next[mpcd_pkg::PCFG_CODE_LSB +: 7] = pcfg_reg[p].code;
                        rdata_next[mpcd_pkg::PCFG_DIR_BIT]       = pcfg_reg[p].dir_in;
                    end
                end
            end
            MPCD_A_SW:  rdata_next[mpcd_pkg::CTL_W-1:0] = ctl_sw_reg;
            MPCD_A_EFF: rdata_next[mpcd_pkg::CTL_W-1:0] = ctl_eff;
            MPCD_A_PIN: begin
                rdata_next[NUM_PINS-1:0] = pin_in;
                rdata_next[mpcd_pkg::PIN_ST_OUT_LSB +: NUM_PINS] = pin_out;
            end
            MPCD_A_BAD: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= rdata_next;
        end
    end

    // error answer for any access to an unmapped word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= (acls == MPCD_A_BAD);
        end
    end

    // ---- checks on pin 0 ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       p0_stat;  // pin 0 is a status output
    logic [6:0] p0_code;  // pin 0 code
    assign p0_stat = ~pcfg_reg[0].dir_in;
    assign p0_code = pcfg_reg[0].code;

    pstep_prim_a: assert property (p0_stat && p0_code == 7'h3E
        |=> pin_out[0] == ($past(sts.p_pstep_evt) && $past(sts.p_pstep_msk)))  // see RQ1
        else $error("primary phase step pin level wrong");

    fa_prim_a: assert property (p0_stat && p0_code == 7'h40 && sts.p_fa_done
        |=> pin_out[0] && pin_oe[0])  // see RQ2
        else $error("primary fast acquisition complete not driven");

    slew_or_a: assert property (p0_stat && p0_code == 7'h42 && sts.d1_slew_lim == '0
        |=> !pin_out[0])  // see RQ9
        else $error("slew OR high with no limiter active");

    perr_or_a: assert property (p0_stat && p0_code == 7'h43 && (|sts.d1_phase_err)
        |=> pin_out[0])  // see RQ10
        else $error("phase error OR missed a channel");

    sec_active_a: assert property (p0_stat && p0_code == 7'h54
        |=> pin_out[0] == (|$past(sts.s_active_src)))  // see RQ15
        else $error("secondary active indication wrong");

    hist_upd_a: assert property (p0_stat && p0_code == 7'h59 && !sts.s_hist_upd_msk
        |=> !pin_out[0])  // see RQ18
        else $error("masked history update reached the pin");

    d2_sync_a: assert property (p0_stat && p0_code == 7'h5C
        |=> pin_out[0] == ($past(sts.d2_sync_evt) && $past(sts.d2_sync_msk)))  // see RQ19
        else $error("second distribution sync level wrong");

    pstep_sec_a: assert property (p0_stat && p0_code == 7'h5E && sts.s_pstep_evt
        && sts.s_pstep_msk |=> pin_out[0])  // see RQ20
        else $error("secondary phase step not driven");

    unassigned_low_a: assert property (p0_stat && (p0_code == 7'h5D || p0_code == 7'h48)
        |=> !pin_out[0])  // see RQ22
        else $error("unassigned status code drove high");

    chain_pd_a: assert property (!p0_stat && p0_code == 7'h60
        |=> ctl_eff[mpcd_pkg::CTL_CHAIN1_PD] == $past(pin_in[0]))  // see RQ3
        else $error("second chain power-down not following pin");

    profile_a: assert property (!p0_stat && p0_code == 7'h46 && pin_in[0]
        |=> ctl_eff[mpcd_pkg::CTL_PROFILE0 + 1] ##1 !pin_oe[0])  // see RQ7
        else $error("profile bit 1 not following pin");

    nshot_a: assert property (!p0_stat && p0_code == 7'h5B && !pin_in[0]
        |=> !ctl_eff[mpcd_pkg::CTL_NSHOT])  // see RQ13
        else $error("burst request set while pin low");

    cov_stat_c: cover property (p0_stat && p0_code == 7'h50 ##1 pin_out[0]);
    cov_ctl_c:  cover property (!p0_stat && p0_code == 7'h41 && pin_in[0]
        ##1 ctl_eff[mpcd_pkg::CTL_FREERUN]);
    cov_err_c:  cover property (psel && penable && pslverr);

endmodule

// [design/mpcd_pkg.sv]
// mpcd_pkg: constants, carriers and decode functions of the pin code decoder.
// assumes: 7-bit function codes, status and control bits supplied by the device core.
package mpcd_pkg;

    // register map, byte addresses on the apb bus
    localparam logic [11:0] REG_PCFG_BASE = 12'h000;  // pin config, one word per pin
    localparam logic [11:0] REG_CTL_SW    = 12'h040;  // software copy of control bits
    localparam logic [11:0] REG_CTL_EFF   = 12'h044;  // effective control bits, read only
    localparam logic [11:0] REG_PIN_ST    = 12'h048;  // pin levels, read only
    localparam int          MAX_PINS      = 8;        // config words reserved

    // pin config field positions
    localparam int PCFG_CODE_LSB = 0;                 // function code, 7 bits
    localparam int PCFG_DIR_BIT  = 8;                 // 1 = control input
    localparam int PIN_ST_OUT_LSB = 8;                // pin drive levels in status word

    // control bit indices
    localparam int CTL_W         = 21;
    localparam int CTL_CHAIN0_PD = 0;                 // first_loop_chain power-down
    localparam int CTL_FREERUN   = 1;                 // primary_digital_loop user freerun
    localparam int CTL_HOLDOVER  = 2;                 // user holdover
    localparam int CTL_CLR_HIST  = 3;                 // clear tuning word history
    localparam int CTL_DIST_SYNC = 4;                 // sync first distribution dividers
    localparam int CTL_PROFILE0  = 5;                 // profile select bits 5..7
    localparam int CTL_GRP0_A    = 8;                 // grp0_out_a mute pos/neg, reset
    localparam int CTL_GRP0_B    = 11;                // grp0_out_b
    localparam int CTL_GRP0_C    = 14;                // grp0_out_c
    localparam int CTL_MUTE_ALL  = 17;                // grp0_all_outputs mute
    localparam int CTL_RST_ALL   = 18;                // grp0_all_outputs driver reset
    localparam int CTL_NSHOT     = 19;                // counted pulse burst request
    localparam int CTL_CHAIN1_PD = 20;                // second_loop_chain power-down
    localparam logic [4:0] CTL_NONE = 5'h1F;          // no control effect

    // reset values
    localparam logic [20:0] CTL_SW_RST = 21'h0_0000;
    localparam logic [7:0]  PCFG_RST   = 8'h00;       // code 0, status direction

    // width of per-channel distribution vectors
    localparam int DIST_CH = 6;

    // pin configuration carrier
    typedef struct packed {
        logic       dir_in;                           // 1 = control input
        logic [6:0] code;                             // function code
    } mpcd_pcfg_t;

    // device status bits feeding the status codes
    typedef struct packed {
        logic               p_pstep_evt;              // primary phase step event
        logic               p_pstep_msk;
        logic               p_fa_act;                 // primary fast acquisition active
        logic               p_fa_done;
        logic               p_fb_resync;              // feedback divider resync
        logic [DIST_CH-1:0] d1_slew_lim;              // first distribution slew limiters
        logic [DIST_CH-1:0] d1_phase_err;             // first distribution phase errors
        logic               s_phase_lock;             // secondary_digital_loop
        logic               s_freq_lock;
        logic               s_analog_lock;            // secondary_analog_loop locked
        logic               s_cal_busy;
        logic [5:0]         s_active_src;             // active indication source bits
        logic               s_freerun;
        logic               s_holdover;
        logic               s_switching;
        logic               s_hist_avail;
        logic               s_freq_clamp;
        logic               s_slew_lim;
        logic               s_hist_upd_evt;
        logic               s_hist_upd_msk;
        logic               d2_sync_evt;              // second distribution synchronized
        logic               d2_sync_msk;
        logic               s_pstep_evt;
        logic               s_pstep_msk;
        logic               s_fa_act;
        logic               s_fa_done;
    } mpcd_sts_t;

    // status level for a code; unassigned codes give low
    function automatic logic sts_sel(input logic [6:0] code, input mpcd_sts_t s);
        logic r;
        r = 1'b0;
        unique case (code)
            7'h3E:   r = s.p_pstep_evt & s.p_pstep_msk;
            7'h3F:   r = s.p_fa_act;
            7'h40:   r = s.p_fa_done;
            7'h41:   r = s.p_fb_resync;                              // see RQ8
            7'h42:   r = |s.d1_slew_lim;
            7'h43:   r = |s.d1_phase_err;
            7'h50:   r = s.s_phase_lock;                             // see RQ14
            7'h51:   r = s.s_freq_lock;
            7'h52:   r = s.s_analog_lock;
            7'h53:   r = s.s_cal_busy;
            7'h54:   r = |s.s_active_src;
            7'h55:   r = s.s_freerun;                                // see RQ16
            7'h56:   r = s.s_holdover;
            7'h57:   r = s.s_switching;
            7'h58:   r = s.s_hist_avail;                             // see RQ17
            7'h59:   r = s.s_hist_upd_evt & s.s_hist_upd_msk;
            7'h5A:   r = s.s_freq_clamp;
            7'h5B:   r = s.s_slew_lim;
            7'h5C:   r = s.d2_sync_evt & s.d2_sync_msk;
            7'h5E:   r = s.s_pstep_evt & s.s_pstep_msk;
            7'h5F:   r = s.s_fa_act;                                 // see RQ21
            7'h60:   r = s.s_fa_done;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // control bit index for a code, CTL_NONE when unassigned
    function automatic logic [4:0] ctl_idx(input logic [6:0] code);
        logic [4:0] r;
        r = CTL_NONE;
        if (code >= 7'h40 && code <= 7'h47) begin
            r = 5'(code - 7'h40);
        end else if (code >= 7'h50 && code <= 7'h5B) begin
            r = 5'(code - 7'h48);
        end else if (code == 7'h60) begin
            r = 5'(CTL_CHAIN1_PD);
        end
        return r;
    endfunction

endpackage

// [design/mpcd_pin_cell.sv]
// mpcd_pin_cell: one multifunction pin, status drive and control proxy index.
// assumes: config and status come from the top, pin input already synchronous.
`timescale 1ns/1ps
module mpcd_pin_cell (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire mpcd_pkg::mpcd_pcfg_t cfg,      // code and direction
    input  wire mpcd_pkg::mpcd_sts_t  sts,      // device status bits
    output logic                    pin_out,  // registered drive level
    output logic                    pin_oe,   // high while driving
    output logic [4:0]              prox_idx  // control bit proxied, or none
);

    // status drive level, low when the pin is an input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
        end else if (cfg.dir_in) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= mpcd_pkg::sts_sel(cfg.code, sts);
        end
    end

    // output enable follows the direction bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= ~cfg.dir_in;
        end
    end

    // which control bit this pin stands in for
    always_comb begin
        prox_idx = mpcd_pkg::CTL_NONE;
        if (cfg.dir_in) begin
            prox_idx = mpcd_pkg::ctl_idx(cfg.code);
        end
    end

endmodule

// [verif/mpcd_host_model.sv]
// mpcd_host_model: host logic on the far side of the multifunction pins.
// assumes: one pclk domain; device drives a pin only while its enable is high.
`timescale 1ns/1ps
module mpcd_host_model #(
    parameter int N    = 2,     // pins modelled
    parameter int HOLD = 4      // a host level stands at least HOLD + 1 cycles
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] want,
    input  wire logic [N-1:0] pin_out,
    input  wire logic [N-1:0] pin_oe,
    output logic      [N-1:0] pin_in,
    output logic      [N-1:0] sensed
);
    logic [N-1:0] drv_reg;      // host drive level
    int           hold_cnt;     // cycles since last drive change, saturating at HOLD

    // new level only once the previous one stood long enough
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_reg  <= '0;
            hold_cnt <= 0;
        end else if (want != drv_reg && hold_cnt >= HOLD) begin
            drv_reg  <= want;
            hold_cnt <= 0;
        end else if (hold_cnt < HOLD) begin
            hold_cnt <= hold_cnt + 1;
        end
    end

    // wire level: device while enabled, host otherwise, so no contention
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : drv_reg[i];
        end
    end
    assign sensed = pin_in;     // host sees the resolved wire
endmodule

// [verif/mpcd_bench.sv]
// mpcd_bench: self-checking bench of the pin code decoder with apb master.
// assumes: pin 0 used first as status output, then as control input.
`timescale 1ns/1ps
module mpcd_bench;
    localparam int NP   = 2;    // pins instantiated
    localparam int HOLD = 4;    // host hold time in cycles
    logic                       pclk;
    logic                       presetn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [11:0]                paddr;
    logic [31:0]                pwdata;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    mpcd_pkg::mpcd_sts_t        sts;
    logic [NP-1:0]              pin_in;
    logic [NP-1:0]              pin_out;
    logic [NP-1:0]              pin_oe;
    logic [NP-1:0]              want;
    logic [mpcd_pkg::CTL_W-1:0] ctl_eff;
    logic [15:0]                seed;   // lfsr state
    int                         mismatches;
    int                         num_checks;

    mpcd_top #(.NUM_PINS(NP)) mpcd_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sts(sts), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .ctl_eff(ctl_eff));

    mpcd_host_model #(.N(NP), .HOLD(HOLD)) mpcd_host_model_i (
        .pclk(pclk), .presetn(presetn), .want(want), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in), .sensed());

    // free-running clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // compare one value
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // 32 random bits from the lfsr
    function automatic logic [31:0] rnd();
        logic [31:0] r;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        r[31:16] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        r[15:0] = seed;
        return r;
    endfunction

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected status level of a code
    function automatic logic m_sts(input logic [6:0] c, input mpcd_pkg::mpcd_sts_t s);
        case (c)
            7'h3E:   return s.p_pstep_evt & s.p_pstep_msk;
            7'h3F:   return s.p_fa_act;
            7'h40:   return s.p_fa_done;
            7'h41:   return s.p_fb_resync;
            7'h42:   return |s.d1_slew_lim;
            7'h43:   return |s.d1_phase_err;
            7'h50:   return s.s_phase_lock;
            7'h51:   return s.s_freq_lock;
            7'h52:   return s.s_analog_lock;
            7'h53:   return s.s_cal_busy;
            7'h54:   return |s.s_active_src;
            7'h55:   return s.s_freerun;
            7'h56:   return s.s_holdover;
            7'h57:   return s.s_switching;
            7'h58:   return s.s_hist_avail;
            7'h5A:   return s.s_freq_clamp;
            7'h5B:   return s.s_slew_lim;
            7'h59:   return s.s_hist_upd_evt & s.s_hist_upd_msk;
            7'h5C:   return s.d2_sync_evt & s.d2_sync_msk;
            7'h5E:   return s.s_pstep_evt & s.s_pstep_msk;
            7'h5F:   return s.s_fa_act;
            7'h60:   return s.s_fa_done;
            default: return 1'b0;
        endcase
    endfunction

    // expected control bit of a code, -1 when none
    function automatic int m_idx(input logic [6:0] c);
        case (c)
            7'h40:               return mpcd_pkg::CTL_CHAIN0_PD;
            7'h60:               return mpcd_pkg::CTL_CHAIN1_PD;
            7'h41:               return mpcd_pkg::CTL_FREERUN;
            7'h42:               return mpcd_pkg::CTL_HOLDOVER;
            7'h43:               return mpcd_pkg::CTL_CLR_HIST;
            7'h44:               return mpcd_pkg::CTL_DIST_SYNC;
            7'h45, 7'h46, 7'h47: return mpcd_pkg::CTL_PROFILE0 + int'(c - 7'h45);
            7'h50, 7'h51, 7'h52: return mpcd_pkg::CTL_GRP0_A + int'(c - 7'h50);
            7'h53, 7'h54, 7'h55: return mpcd_pkg::CTL_GRP0_B + int'(c - 7'h53);
            7'h56, 7'h57, 7'h58: return mpcd_pkg::CTL_GRP0_C + int'(c - 7'h56);
            7'h59:               return mpcd_pkg::CTL_MUTE_ALL;
            7'h5A:               return mpcd_pkg::CTL_RST_ALL;
            7'h5B:               return mpcd_pkg::CTL_NSHOT;
            default:             return -1;
        endcase
    endfunction

    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        finish_test();
    end

    // main sequence
    initial begin
        logic [31:0] rd, sw;
        logic [63:0] w;
        logic [20:0] exp;
        logic        err;
        int          idx;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        sts = '0;
        want = '0;
        seed = 16'hA2E7;        // 41703
        mismatches = 0;
        num_checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        apb(1'b0, mpcd_pkg::REG_CTL_SW, '0, rd, err);
        check("ctl_sw reset", rd, 32'(mpcd_pkg::CTL_SW_RST));
        apb(1'b0, mpcd_pkg::REG_PCFG_BASE, '0, rd, err);
        check("pcfg reset", rd, 32'(mpcd_pkg::PCFG_RST));
        check("oe reset", 32'(pin_oe), 32'(2'h3));
        check("ctl_eff reset", 32'(ctl_eff), '0);
        $display("reset test done");
        // every status code on pin 0, zeros, ones and random status
        for (int c = 'h3E; c <= 'h60; c++) begin
            apb(1'b1, mpcd_pkg::REG_PCFG_BASE, 32'(c), rd, err);
            for (int k = 0; k < 6; k++) begin
                w = (k == 0) ? '0 : (k == 1) ? '1 : {rnd(), rnd()};
                sts <= w[$bits(mpcd_pkg::mpcd_sts_t)-1:0];
                repeat (3) @(posedge pclk);
                check("status pin", 32'(pin_out[0]), 32'(m_sts(7'(c), sts)));
                check("status oe", 32'(pin_oe[0]), 32'h0000_0001);
            end
        end
        $display("status test done");
        // every code as control on pin 0, both levels over random software bits
        for (int c = 'h3E; c <= 'h60; c++) begin
            apb(1'b1, mpcd_pkg::REG_PCFG_BASE,
                (32'h0000_0001 << mpcd_pkg::PCFG_DIR_BIT) | 32'(c), rd, err);
            for (int lvl = 0; lvl < 2; lvl++) begin
                sw = rnd();
                apb(1'b1, mpcd_pkg::REG_CTL_SW, sw, rd, err);
                want <= {1'b0, 1'(lvl)};
                repeat (HOLD + 4) @(posedge pclk);
                exp = sw[20:0];
                idx = m_idx(7'(c));
                if (idx >= 0) begin
                    exp[idx] = 1'(lvl);
                end
                check("ctl_eff port", 32'(ctl_eff), 32'(exp));
                apb(1'b0, mpcd_pkg::REG_CTL_EFF, '0, rd, err);
                check("ctl_eff reg", rd, 32'(exp));
                apb(1'b0, mpcd_pkg::REG_CTL_SW, '0, rd, err);
                check("ctl_sw", rd, 32'(sw[20:0]));
                check("control oe", 32'(pin_oe[0]), '0);
            end
        end
        $display("control test done");
        // unmapped and unaligned accesses are refused and change nothing
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, (k == 0) ? 12'h0F0 : 12'h042, '1, rd, err);
            check("bad write err", 32'(err), 32'h0000_0001);
            apb(1'b0, (k == 0) ? 12'h0F0 : 12'h042, '0, rd, err);
            check("bad read data", rd, '0);
            apb(1'b0, mpcd_pkg::REG_CTL_SW, '0, rd, err);
            check("ctl_sw kept", rd, 32'(sw[20:0]));
        end
        $display("error test done");
        finish_test();
    end
endmodule
